/* common/slu_pkg.sv */
// Purpose: Shared constants and types for the dual serial line unit.
// Assumes: 10 MHz ref_clk, synchronous active-high reset.
// Notes: Behaviour summary follows.
package slu_pkg;
    localparam int NUM_UNITS = 2;
    localparam int DATA_W = 8;
    localparam int BUS_W = 16;
    localparam int FLAG_BIT = 7;
    localparam int IE_BIT = 6;
    localparam int RX_FIFO_DEPTH = 8;
    // Bit clock ticks per bit and the tick that marks a bit centre
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] HALF_LAST = 4'h7;
    // Baud reference synthesised from ref_clk by phase accumulation
    localparam int REF_CLK_HZ = 10_000_000;
    localparam int BAUD_REF_HZ = 5_068_800;
    localparam logic [23:0] REF_STEP = 24'(BAUD_REF_HZ / 100);
    localparam logic [23:0] REF_MOD = 24'(REF_CLK_HZ / 100);
    // Divisor for switch code n is (16 - n) * BAUD_DIV_UNIT
    localparam logic [15:0] BAUD_DIV_UNIT = 16'h0021;
    // Vector defaults (plain values)
    localparam logic [7:0] VEC_CONSOLE = 8'h30;
    localparam logic [7:0] VEC_SECOND = 8'hC0;
    localparam logic [7:0] VEC_SECOND_ALT = 8'hC8;
    localparam logic [7:0] VEC_TX_OFFSET = 8'h04;
    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA = 5'b00100,
        RX_PAR = 5'b01000,
        RX_STOP = 5'b10000
    } rxState_e;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SHIFT = 2'b10
    } txState_e;
endpackage

/* common/fifo_if.sv */
// Purpose: Valid/ready carrier between a FIFO and its user.
// Assumes: One clock domain.
// Notes: store is the FIFO side, user the producer and consumer side.
`timescale 1ns/1ps
interface fifo_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] wrData;
    logic wrValid;
    logic wrReady;
    logic [WIDTH-1:0] rdData;
    logic rdValid;
    logic rdReady;
    modport store(input wrData, input wrValid, input rdReady, output wrReady, output rdData, output rdValid);
    modport user(output wrData, output wrValid, output rdReady, input wrReady, input rdData, input rdValid);
endinterface

/* core/sync_fifo.sv */
// Purpose: Synchronous FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes: Full and empty are exact; simultaneous push and pop allowed.
`timescale 1ns/1ps
module sync_fifo
    import slu_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    fifo_if.store port
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [AW:0] count_q, count_d;
    logic push, pop;

    // Handshakes straight from the occupancy count
    assign port.wrReady = (count_q != (AW+1)'(DEPTH));
    assign port.rdValid = (count_q != '0);
    assign port.rdData = mem_q[rdPtr_q];
    assign push = port.wrValid & port.wrReady;
    assign pop = port.rdValid & port.rdReady;

    // Pointer and count update
    always_comb begin
        wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
        rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
        count_d = count_q;
        if (push & ~pop) begin
            count_d = count_q + 1'b1;
        end else if (pop & ~push) begin
            count_d = count_q - 1'b1;
        end
    end

    // Storage has no reset; only occupancy state does
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wrPtr_q] <= port.wrData;
        end
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
        end
    end
endmodule

/* core/dual_serial_line_unit.sv */
// Purpose: Two serial line units with status, buffers, interrupts and baud generation.
// Assumes: All strobes are active-high one-cycle pulses synchronous to ref_clk.
// Notes: Register reads answer on internalDataOut one cycle after the strobe.
`timescale 1ns/1ps
module dual_serial_line_unit
    import slu_pkg::*;
#(
    parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [BUS_W-1:0] internalDataIn,
    output logic [BUS_W-1:0] internalDataOut,
    output logic internalDataOe,
    input wire logic [NUM_UNITS-1:0] rxBufferReadStrobe,
    input wire logic [NUM_UNITS-1:0] txBufferLoadStrobe,
    input wire logic [NUM_UNITS-1:0] rxStatusLoadStrobe,
    input wire logic [NUM_UNITS-1:0] txStatusLoadStrobe,
    input wire logic rxStatusReadStrobe,
    input wire logic txStatusReadStrobe,
    input wire logic latchedAddrBitNine,
    input wire logic vectorPhaseStrobe,
    input wire logic vectorReadStrobe,
    output logic ackChainOut,
    output logic serialIntRequest,
    input wire logic secondUnitAddrJumper,
    input wire logic baudGenEnable,
    input wire logic [3:0] baudSelectConsole,
    input wire logic [3:0] baudSelectSecond,
    input wire logic [NUM_UNITS-1:0] unitBitClock,
    input wire logic fmtEightBits,
    input wire logic fmtTwoStop,
    input wire logic fmtParityOn,
    input wire logic fmtParityOdd,
    input wire logic [NUM_UNITS-1:0] serialRxLine,
    output logic [NUM_UNITS-1:0] serialTxLine
);
    wire logic [NUM_UNITS-1:0] rxDoneFlag, rxIntEnable, txReadyFlag, txIntEnable;
    wire logic [NUM_UNITS-1:0] actRx, actTx, pendRx, pendTx;
    logic [NUM_UNITS-1:0] ackRx, ackTx;
    wire logic [DATA_W-1:0] rxBufWord [NUM_UNITS];
    logic [23:0] refAcc_q, refAcc_d;
    logic refTick_q, refTick_d;
    logic [BUS_W-1:0] dataOut_q, dataOut_d;
    logic dataOe_q, dataOe_d;
    logic consoleActive, secondActive, ackSecond, ackIsTx;
    logic [DATA_W-1:0] vector;
    logic [3:0] dataBits;

    assign dataBits = fmtEightBits ? 4'h8 : 4'h7;

    // Acknowledge chain: console first, second unit only if console idle
    always_comb begin
        consoleActive = actRx[0] | actTx[0];
        secondActive = actRx[1] | actTx[1];
        ackSecond = ~consoleActive;
        ackChainOut = vectorReadStrobe & ~consoleActive & ~secondActive;
        ackRx = '0;
        ackTx = '0;
        // Receive channel wins inside a unit
        ackIsTx = ackSecond ? ~actRx[1] : ~actRx[0];
        if (vectorReadStrobe) begin
            ackRx[0] = ~ackSecond & actRx[0];
            ackTx[0] = ~ackSecond & ~actRx[0] & actTx[0];
            ackRx[1] = ackSecond & actRx[1];
            ackTx[1] = ackSecond & ~actRx[1] & actTx[1];
        end
        if (~ackSecond) begin
            vector = VEC_CONSOLE;
        end else if (secondUnitAddrJumper) begin
            vector = VEC_SECOND_ALT;
        end else begin
            vector = VEC_SECOND;
        end
        if (ackIsTx) begin
            vector = vector + VEC_TX_OFFSET;
        end
    end

    // Read multiplexer and baud reference accumulator
    always_comb begin
        refAcc_d = refAcc_q + REF_STEP;
        refTick_d = 1'b0;
        if (refAcc_d >= REF_MOD) begin
            refAcc_d = refAcc_d - REF_MOD;
            refTick_d = 1'b1;
        end
        dataOut_d = '0;
        dataOe_d = 1'b1;
        if (vectorReadStrobe) begin
            dataOut_d[DATA_W-1:0] = (consoleActive | secondActive) ? vector : '0;
        end else if (rxBufferReadStrobe[0]) begin
            dataOut_d[DATA_W-1:0] = rxBufWord[0];
        end else if (rxBufferReadStrobe[1]) begin
            dataOut_d[DATA_W-1:0] = rxBufWord[1];
        end else if (rxStatusReadStrobe) begin
            // Bit nine high picks the console unit
            dataOut_d[FLAG_BIT] = latchedAddrBitNine ? rxDoneFlag[0] : rxDoneFlag[1];
            dataOut_d[IE_BIT] = latchedAddrBitNine ? rxIntEnable[0] : rxIntEnable[1];
        end else if (txStatusReadStrobe) begin
            dataOut_d[FLAG_BIT] = latchedAddrBitNine ? txReadyFlag[0] : txReadyFlag[1];
            dataOut_d[IE_BIT] = latchedAddrBitNine ? txIntEnable[0] : txIntEnable[1];
        end else begin
            dataOe_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            refAcc_q <= '0;
            refTick_q <= 1'b0;
            dataOut_q <= '0;
            dataOe_q <= 1'b0;
        end else begin
            refAcc_q <= refAcc_d;
            refTick_q <= refTick_d;
            dataOut_q <= dataOut_d;
            dataOe_q <= dataOe_d;
        end
    end

    assign internalDataOut = dataOut_q;
    assign internalDataOe = dataOe_q;
    assign serialIntRequest = |{actRx, actTx, pendRx, pendTx};

    for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
        fifo_if #(.WIDTH(DATA_W)) rxq();
        logic [3:0] baudSel;
        logic [15:0] divisor;
        logic bitTick;
        logic [15:0] divCnt_q, divCnt_d;
        logic bitClkPrev_q;
        rxState_e rxState_q, rxState_d;
        logic [3:0] rxTick_q, rxTick_d, rxBits_q, rxBits_d;
        logic [DATA_W-1:0] rxShift_q, rxShift_d, rxBuf_q, rxBuf_d;
        logic rxLinePrev_q, rxPush_q, rxPush_d, rxDone_q, rxDone_d, rxIe_q, rxIe_d;
        txState_e txState_q, txState_d;
        logic [11:0] txShift_q, txShift_d, frame;
        logic [3:0] txTick_q, txTick_d, txBits_q, txBits_d, frameLen;
        logic [DATA_W-1:0] txBuf_q, txBuf_d, dataMask;
        logic txFull_q, txFull_d, txIe_q, txIe_d;
        logic rxReqPrev_q, txReqPrev_q, rxReq, txReq;
        logic pendRx_q, pendRx_d, pendTx_q, pendTx_d, actRx_q, actRx_d, actTx_q, actTx_d;

        sync_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
            .ref_clk(ref_clk),
            .rst(rst),
            .port(rxq.store)
        );

        assign baudSel = (u == 0) ? baudSelectConsole : baudSelectSecond;
        assign divisor = BAUD_DIV_UNIT * {11'h000, 5'h10 - {1'b0, baudSel}};
        // One tick drives both receiver and transmitter of this unit
        assign bitTick = baudGenEnable ? (refTick_q && divCnt_q == 16'h0000)
                                       : (unitBitClock[u] & ~bitClkPrev_q);
        assign rxReq = rxDone_q & rxIe_q;
        assign txReq = ~txFull_q & txIe_q;
        assign dataMask = fmtEightBits ? 8'hFF : 8'h7F;
        assign frameLen = 4'h1 + dataBits + {3'h0, fmtParityOn} + (fmtTwoStop ? 4'h2 : 4'h1);
        // Frame sent LSB first: start, data, optional parity, then idle-high stops
        always_comb begin
            frame = '1;
            frame[0] = 1'b0;
            frame[DATA_W:1] = txBuf_q | ~dataMask;
            if (~fmtEightBits) begin
                frame[DATA_W] = 1'b1;
            end
            if (fmtParityOn) begin
                frame[dataBits+4'h1] = ^(txBuf_q & dataMask) ^ fmtParityOdd;
            end
        end

        assign rxq.wrData = rxShift_q >> (fmtEightBits ? 0 : 1);
        assign rxq.wrValid = rxPush_q;
        assign rxq.rdReady = ~rxDone_q;

        always_comb begin
            divCnt_d = divCnt_q;
            if (refTick_q) begin
                divCnt_d = (divCnt_q == 16'h0000) ? divisor - 16'h0001 : divCnt_q - 16'h0001;
            end
            // Receiver: edge-started, centre-sampled
            rxState_d = rxState_q;
            rxTick_d = rxTick_q;
            rxBits_d = rxBits_q;
            rxShift_d = rxShift_q;
            rxPush_d = 1'b0;
            case (rxState_q)
                RX_IDLE: begin
                    if (rxLinePrev_q & ~serialRxLine[u]) begin
                        rxState_d = RX_START;
                        rxTick_d = '0;
                    end
                end
                RX_START: begin
                    if (bitTick) begin
                        rxTick_d = rxTick_q + 4'h1;
                        if (rxTick_q == HALF_LAST) begin
                            // A glitch that is high at mid-start is ignored
                            rxState_d = serialRxLine[u] ? RX_IDLE : RX_DATA;
                            rxTick_d = '0;
                            rxBits_d = '0;
                        end
                    end
                end
                RX_DATA, RX_PAR, RX_STOP: begin
                    if (bitTick) begin
                        rxTick_d = rxTick_q + 4'h1;
                        if (rxTick_q == TICK_LAST) begin
                            if (rxState_q == RX_DATA) begin
                                rxShift_d = {serialRxLine[u], rxShift_q[DATA_W-1:1]};
                                rxBits_d = rxBits_q + 4'h1;
                                if (rxBits_q == dataBits - 4'h1) begin
                                    rxState_d = fmtParityOn ? RX_PAR : RX_STOP;
                                end
                            end else if (rxState_q == RX_PAR) begin
                                rxState_d = RX_STOP;
                            end else begin
                                // Overrun: a full queue drops the new character
                                rxPush_d = serialRxLine[u];
                                rxState_d = RX_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    rxState_d = RX_IDLE;
                end
            endcase
            // Buffer and status bits
            rxBuf_d = rxBuf_q;
            rxDone_d = rxDone_q & ~rxBufferReadStrobe[u];
            if (rxq.rdValid & rxq.rdReady) begin
                rxBuf_d = rxq.rdData;
                rxDone_d = 1'b1;
            end
            rxIe_d = rxStatusLoadStrobe[u] ? internalDataIn[IE_BIT] : rxIe_q;
            txIe_d = txStatusLoadStrobe[u] ? internalDataIn[IE_BIT] : txIe_q;
            // Transmitter
            txState_d = txState_q;
            txShift_d = txShift_q;
            txTick_d = txTick_q;
            txBits_d = txBits_q;
            txBuf_d = txBuf_q;
            txFull_d = txFull_q;
            case (txState_q)
                TX_IDLE: begin
                    if (txFull_q) begin
                        txShift_d = frame;
                        txFull_d = 1'b0;
                        txTick_d = '0;
                        txBits_d = frameLen;
                        txState_d = TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (bitTick) begin
                        txTick_d = txTick_q + 4'h1;
                        if (txTick_q == TICK_LAST) begin
                            txShift_d = {1'b1, txShift_q[11:1]};
                            txBits_d = txBits_q - 4'h1;
                            if (txBits_q == 4'h1) begin
                                txState_d = TX_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    txState_d = TX_IDLE;
                end
            endcase
            if (txBufferLoadStrobe[u]) begin
                txBuf_d = internalDataIn[DATA_W-1:0];
                txFull_d = 1'b1;
            end
            // Pending on rising request, held while it lasts, cleared by acknowledge
            pendRx_d = rxReq & ((pendRx_q & ~ackRx[u]) | ~rxReqPrev_q);
            pendTx_d = txReq & ((pendTx_q & ~ackTx[u]) | ~txReqPrev_q);
            actRx_d = actRx_q;
            actTx_d = actTx_q;
            if (vectorPhaseStrobe) begin
                actRx_d = pendRx_q;
                actTx_d = pendTx_q;
            end else if (vectorReadStrobe) begin
                actRx_d = 1'b0;
                actTx_d = 1'b0;
                pendRx_d = pendRx_d & ~ackRx[u];
                pendTx_d = pendTx_d & ~ackTx[u];
            end
        end

        always_ff @(posedge ref_clk) begin
            if (rst) begin
                divCnt_q <= '0;
                bitClkPrev_q <= 1'b0;
                rxState_q <= RX_IDLE;
                rxTick_q <= '0;
                rxBits_q <= '0;
                rxShift_q <= '0;
                rxBuf_q <= '0;
                rxLinePrev_q <= 1'b1;
                rxPush_q <= 1'b0;
                rxDone_q <= 1'b0;
                rxIe_q <= 1'b0;
                txState_q <= TX_IDLE;
                txShift_q <= '1;
                txTick_q <= '0;
                txBits_q <= '0;
                txBuf_q <= '0;
                txFull_q <= 1'b0;
                txIe_q <= 1'b0;
                rxReqPrev_q <= 1'b0;
                txReqPrev_q <= 1'b0;
                pendRx_q <= 1'b0;
                pendTx_q <= 1'b0;
                actRx_q <= 1'b0;
                actTx_q <= 1'b0;
            end else begin
                divCnt_q <= divCnt_d;
                bitClkPrev_q <= unitBitClock[u];
                rxState_q <= rxState_d;
                rxTick_q <= rxTick_d;
                rxBits_q <= rxBits_d;
                rxShift_q <= rxShift_d;
                rxBuf_q <= rxBuf_d;
                rxLinePrev_q <= serialRxLine[u];
                rxPush_q <= rxPush_d;
                rxDone_q <= rxDone_d;
                rxIe_q <= rxIe_d;
                txState_q <= txState_d;
                txShift_q <= txShift_d;
                txTick_q <= txTick_d;
                txBits_q <= txBits_d;
                txBuf_q <= txBuf_d;
                txFull_q <= txFull_d;
                txIe_q <= txIe_d;
                rxReqPrev_q <= rxReq;
                txReqPrev_q <= txReq;
                pendRx_q <= pendRx_d;
                pendTx_q <= pendTx_d;
                actRx_q <= actRx_d;
                actTx_q <= actTx_d;
            end
        end

        assign rxDoneFlag[u] = rxDone_q;
        assign rxIntEnable[u] = rxIe_q;
        assign txReadyFlag[u] = ~txFull_q;
        assign txIntEnable[u] = txIe_q;
        assign actRx[u] = actRx_q;
        assign actTx[u] = actTx_q;
        assign pendRx[u] = pendRx_q;
        assign pendTx[u] = pendTx_q;
        assign rxBufWord[u] = rxBuf_q;
        assign serialTxLine[u] = txShift_q[0];
    end
endmodule

/* bench/slu_properties.sv */
// Purpose: Port-level checks for the dual serial line unit.
// Assumes: Strobes are one-cycle active-high pulses on ref_clk.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
module slu_checker
    import slu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [BUS_W-1:0] internalDataOut,
    input wire logic internalDataOe,
    input wire logic [NUM_UNITS-1:0] rxBufferReadStrobe,
    input wire logic rxStatusReadStrobe,
    input wire logic txStatusReadStrobe,
    input wire logic vectorReadStrobe,
    input wire logic ackChainOut,
    input wire logic serialIntRequest,
    input wire logic [NUM_UNITS-1:0] serialTxLine
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic anyRd;
    logic hiRd;
    // Read priority: vector, buffers, then status
    assign anyRd = vectorReadStrobe | (|rxBufferReadStrobe) | rxStatusReadStrobe | txStatusReadStrobe;
    assign hiRd = vectorReadStrobe | (|rxBufferReadStrobe);
    sequence s_read;
        anyRd ##1 internalDataOe;
    endsequence
    chk_read_answer: assert property (anyRd |-> s_read)
        else $error("read strobe without bus answer");
    chk_quiet_bus: assert property (!anyRd |=> !internalDataOe && internalDataOut == 16'h0000)
        else $error("bus driven without a read");
    chk_buf_upper: assert property (!vectorReadStrobe && |rxBufferReadStrobe |=> internalDataOut[15:8] == 8'h00)
        else $error("buffer read upper byte not zero");
    chk_rx_status: assert property (rxStatusReadStrobe && !hiRd |=> (internalDataOut & 16'hFF3F) == 16'h0000)
        else $error("receive status spare bits set");
    chk_tx_status: assert property (txStatusReadStrobe && !hiRd && !rxStatusReadStrobe
        |=> (internalDataOut & 16'hFF3F) == 16'h0000)
        else $error("transmit status spare bits set");
    chk_ack_idle: assert property (!vectorReadStrobe |-> !ackChainOut)
        else $error("acknowledge passed outside vector read");
    chk_ack_passes: assert property (vectorReadStrobe && !serialIntRequest |-> ackChainOut)
        else $error("acknowledge held with nothing armed");
    chk_vector_shape: assert property (vectorReadStrobe && !ackChainOut
        |=> internalDataOut[15:8] == 8'h00 && internalDataOut[1:0] == 2'b00 && internalDataOut[7:0] != 8'h00)
        else $error("vector malformed");
    chk_empty_vector: assert property (vectorReadStrobe && ackChainOut |=> internalDataOut == 16'h0000)
        else $error("vector returned with acknowledge passed");
    chk_reset_idle: assert property ($past(rst) |-> serialTxLine == 2'b11 && !serialIntRequest)
        else $error("line or request active after reset");
endmodule
bind dual_serial_line_unit slu_checker u_slu_checker(.ref_clk(ref_clk), .rst(rst), .internalDataOut(internalDataOut),
    .internalDataOe(internalDataOe), .rxBufferReadStrobe(rxBufferReadStrobe), .rxStatusReadStrobe(rxStatusReadStrobe),
    .txStatusReadStrobe(txStatusReadStrobe), .vectorReadStrobe(vectorReadStrobe), .ackChainOut(ackChainOut),
    .serialIntRequest(serialIntRequest), .serialTxLine(serialTxLine));

/* bench/term_model.sv */
// Purpose: Terminal on both serial lines, 8 data bits, no parity, one stop.
// Assumes: Bit clock ticks every second ref_clk cycle, so a bit is 32 cycles.
// Notes: Lines idle at mark level, as the line drivers pull them.
`timescale 1ns/1ps
module term_model (
    input wire logic ref_clk,
    input wire logic [1:0] devTx,
    output logic [1:0] devRx
);
    localparam int BIT_CYC = 32;
    initial devRx = 2'b11;
    // Start, data LSB first, stop; ends at mark
    task automatic send_byte(input int u, input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk);
            devRx[u] <= f[i];
            repeat (BIT_CYC - 1) @(posedge ref_clk);
        end
    endtask
    // Waits for a start bit under a bound; a miss returns unknowns
    task automatic get_byte(input int u, output logic [7:0] b);
        int n;
        n = 0;
        b = 'x;
        while (devTx[u] !== 1'b0 && n < 2000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n < 2000) begin
            repeat (BIT_CYC / 2) @(posedge ref_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge ref_clk);
                b[i] = devTx[u];
            end
            repeat (BIT_CYC) @(posedge ref_clk);
        end
    endtask
endmodule

/* bench/testbench.sv */
// Purpose: Register, vector and serial checks of the dual serial line unit.
// Assumes: External bit clock path, 8N1 format, except one 7E1 frame and one internal-generator frame.
// Notes: Reads answer one cycle after the strobe edge.
`timescale 1ns/1ps
module testbench;
    import slu_pkg::*;
    logic ref_clk = 0, rst = 1, a9 = 0, vPh = 0, vRd = 0, jmp = 0, rsR = 0, tsR = 0, oe, ack, irq;
    logic f8 = 1, pOn = 0, gen = 0;
    logic [15:0] dIn = 0, dOut, d;
    logic [1:0] rbR = 0, tbL = 0, rsL = 0, tsL = 0, bitClk = 0, rxLine, txLine;
    logic [3:0] bSel = 4'hF;
    logic [7:0] b;
    int error_cnt = 0, compares = 0, n;
    always #50 ref_clk = ~ref_clk;
    // External 16x clock: one tick every two cycles
    always @(posedge ref_clk) bitClk <= ~bitClk;
    dual_serial_line_unit u_dual_serial_line_unit(.ref_clk(ref_clk), .rst(rst), .internalDataIn(dIn),
        .internalDataOut(dOut), .internalDataOe(oe), .rxBufferReadStrobe(rbR), .txBufferLoadStrobe(tbL),
        .rxStatusLoadStrobe(rsL), .txStatusLoadStrobe(tsL), .rxStatusReadStrobe(rsR), .txStatusReadStrobe(tsR),
        .latchedAddrBitNine(a9), .vectorPhaseStrobe(vPh), .vectorReadStrobe(vRd), .ackChainOut(ack),
        .serialIntRequest(irq), .secondUnitAddrJumper(jmp), .baudGenEnable(gen), .baudSelectConsole(bSel),
        .baudSelectSecond(bSel), .unitBitClock(bitClk), .fmtEightBits(f8), .fmtTwoStop(1'b0),
        .fmtParityOn(pOn), .fmtParityOdd(1'b0), .serialRxLine(rxLine), .serialTxLine(txLine));
    term_model u_term_model(.ref_clk(ref_clk), .devTx(txLine), .devRx(rxLine));
    task give_verdict;
        if (error_cnt == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // Kind 0 buffer, 1 rx status, 2 tx status, 3 vector; a missing enable reads as unknown
    task rd(input int k, input logic u, output logic [15:0] v);
        @(posedge ref_clk);
        a9 <= ~u;
        rbR <= (k == 0) ? 2'(1 << u) : 2'b00;
        rsR <= (k == 1);
        tsR <= (k == 2);
        vRd <= (k == 3);
        @(posedge ref_clk);
        {rbR, rsR, tsR, vRd} <= '0;
        #1 v = (oe === 1'b1) ? dOut : 'x;
    endtask
    // Kind 0 transmit buffer, 1 rx status, 2 tx status
    task wr(input int k, input logic u, input logic [15:0] v);
        @(posedge ref_clk);
        dIn <= v;
        tbL <= (k == 0) ? 2'(1 << u) : 2'b00;
        rsL <= (k == 1) ? 2'(1 << u) : 2'b00;
        tsL <= (k == 2) ? 2'(1 << u) : 2'b00;
        @(posedge ref_clk);
        {tbL, rsL, tsL} <= '0;
    endtask
    task vec(output logic [15:0] v);
        @(posedge ref_clk);
        vPh <= 1'b1;
        @(posedge ref_clk);
        vPh <= 1'b0;
        rd(3, 0, v);
    endtask
    // Bounded wait for the receive flag
    task poll(input logic u);
        for (int i = 0; i < 100; i++) begin
            rd(1, u, d);
            if (d[7] === 1'b1) return;
        end
        chk("receive flag wait", 16'h0080, d);
        give_verdict;
    endtask
    // Counts cycles while the second line holds lvl; the bound keeps a dead line from hanging
    task span(input logic lvl, output int c);
        for (c = 0; c < 3000 && txLine[1] === lvl; c++) @(posedge ref_clk);
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rd(2, 0, d); chk("tx status console", 16'h0080, d);
        rd(1, 1, d); chk("rx status second", 16'h0000, d);
        wr(2, 1, 16'hFFFF);
        rd(2, 1, d); chk("tx status second", 16'h00C0, d);
        chk("request second tx", 16'h0001, {15'h0000, irq});
        vec(d); chk("vector second tx", 16'h00C4, d);
        vec(d); chk("vector after clear", 16'h0000, d);
        jmp <= 1'b1;
        wr(0, 1, 16'h0055);
        u_term_model.get_byte(1, b); chk("line second", 16'h0055, {8'h00, b});
        vec(d); chk("vector jumper", 16'h00CC, d);
        wr(2, 1, 16'h0000);
        jmp <= 1'b0;
        // Second load lands while the shifter is busy
        wr(0, 0, 16'h12A5);
        wr(0, 0, 16'h003C);
        rd(2, 0, d); chk("tx ready busy", 16'h0000, d);
        u_term_model.get_byte(0, b); chk("line first", 16'h00A5, {8'h00, b});
        u_term_model.get_byte(0, b); chk("line queued", 16'h003C, {8'h00, b});
        rd(2, 0, d); chk("tx ready idle", 16'h0080, d);
        // Seven bits, even parity: 0x43 has three ones, so the parity bit shows as bit 7
        f8 <= 1'b0;
        pOn <= 1'b1;
        wr(0, 0, 16'h0043);
        u_term_model.get_byte(0, b); chk("line seven even", 16'h00C3, {8'h00, b});
        f8 <= 1'b1;
        pOn <= 1'b0;
        u_term_model.send_byte(0, 8'h3C);
        poll(0);
        wr(1, 0, 16'h0040);
        wr(2, 0, 16'h0040);
        vec(d); chk("vector rx first", 16'h0030, d);
        vec(d); chk("vector tx next", 16'h0034, d);
        rd(0, 0, d); chk("rx buffer console", 16'h003C, d);
        rd(1, 0, d); chk("rx status cleared", 16'h0040, d);
        wr(1, 0, 16'h0000);
        wr(2, 0, 16'h0000);
        u_term_model.send_byte(1, 8'hC3);
        poll(1);
        rd(0, 1, d); chk("rx buffer second", 16'h00C3, d);
        // Internal generator, code F: a bit is 16 ticks of 33 reference periods, about 1042 cycles
        gen <= 1'b1;
        wr(0, 1, 16'h0055);
        span(1'b1, n);
        span(1'b0, n);
        span(1'b1, n);
        chk("generator bit span", 16'h0001, {15'h0000, n > 1038 && n < 1046});
        give_verdict;
    end
endmodule
